// ==== rtl/bscr_pkg.sv ====
// constants for the secondary interrupt and capability register slice
package bscr_pkg;
  // dword offsets in configuration space
  localparam logic [7:0] BSCR_OFS_IRQ = 8'h7C;
  localparam logic [7:0] BSCR_OFS_CAP = 8'h80;
  // fixed byte values and reset values
  localparam logic [7:0] BSCR_IRQ_LINE_RST = 8'h00;
  localparam logic [7:0] BSCR_PIN_FWD = 8'h01;
  localparam logic [7:0] BSCR_PIN_REV = 8'h00;
  localparam logic [7:0] BSCR_MIN_GNT = 8'h00;
  localparam logic [7:0] BSCR_MAX_LAT = 8'h00;
  localparam logic [7:0] BSCR_CAP_ID = 8'h07;
  localparam logic [7:0] BSCR_NEXT_PTR = 8'h90;
  // secondary status field positions
  localparam int BSCR_BIT_WIDE = 16;
  localparam int BSCR_BIT_FAST = 17;
  localparam int BSCR_FLAG_LSB = 18;
  localparam int BSCR_NUM_FLAGS = 4;
  localparam int BSCR_CLK_LSB = 22;
  localparam int BSCR_CLK_MSB = 24;
  localparam int BSCR_RSVD_LSB = 25;
  // flag indices inside the sticky group
  localparam int BSCR_FL_DISCARD = 0;
  localparam int BSCR_FL_UNEXP = 1;
  localparam int BSCR_FL_OVERRUN = 2;
  localparam int BSCR_FL_DELAYED = 3;
  // byte lanes
  localparam int BSCR_LANE_LINE = 0;
  localparam int BSCR_LANE_FLAGS = 2;
  // secondary clock frequency codes
  localparam logic [2:0] BSCR_CLK_CONV = 3'h0;
  localparam logic [2:0] BSCR_CLK_66 = 3'h1;
  localparam logic [2:0] BSCR_CLK_133 = 3'h2;
  localparam logic [2:0] BSCR_CLK_RST = 3'h0;
endpackage : bscr_pkg

// ==== rtl/bscr_sticky_flag.sv ====
// one sticky status flag, set by hardware, cleared by writing one
module bscr_sticky_flag (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_flag
);
  logic flag_ff;
  logic nxt_flag;

  // set wins over a clear in the same cycle
  assign nxt_flag = i_set | (flag_ff & ~i_clr);

  // flag storage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign o_flag = flag_ff;
endmodule : bscr_sticky_flag

// ==== rtl/bscr_cfg_read.sv ====
// registered read data and acknowledge for configuration accesses
module bscr_cfg_read (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_rd,
  input wire logic i_sel_irq,
  input wire logic i_sel_cap,
  input wire logic [31:0] i_irq_word,
  input wire logic [31:0] i_cap_word,
  output logic [31:0] o_rdata,
  output logic o_ack
);
  logic [31:0] rdata_ff;
  logic ack_ff;
  logic [31:0] nxt_rdata;

  // unmapped offsets and writes return zero
  assign nxt_rdata = !i_rd ? 32'h0000_0000 :
                     i_sel_irq ? i_irq_word :
                     i_sel_cap ? i_cap_word : 32'h0000_0000;

  // answer one cycle after the request
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      ack_ff <= i_req;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_ack = ack_ff;
endmodule : bscr_cfg_read

// ==== rtl/bscr_regs.sv ====
// secondary interrupt bytes, capability header and secondary status slice
// How it works
// - interrupt line byte is read-write, forward mode meaning, resets to zero
// - interrupt pin byte reads 01h forward, 00h reverse, read-only
// - minimum grant byte read-only, quarter-microsecond units, resets zero
// - maximum latency byte read-only, quarter-microsecond units, resets zero
// - capability identifier byte reads 07h, read-only
// - next capability pointer reads 90h, read-only
// - status bit 16 is forward mode and wide-bus strap high
// - status bit 17 reads one in forward mode, zero in reverse
// - bit 18 sets on discarded split completion, forward only
// - bit 19 sets on unexpected split completion, reverse only
// - bit 20 sets on split completion overrun, buffer full
// - bit 21 sets when split request is delayed by commitment limit
// - clock field codes 000, 001, 010; others reserved
// - clock field reads zero in reverse mode, resets zero
module bscr_regs (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_CFG_RD,
  input wire logic I_CFG_WR,
  input wire logic [7:0] I_CFG_ADDR,
  input wire logic [3:0] I_CFG_BE,
  input wire logic [31:0] I_CFG_WDATA,
  input wire logic I_FWD_MODE,
  input wire logic I_WIDE_BUS_STRAP,
  input wire logic [2:0] I_SEC_CLK_CODE,
  input wire logic I_SC_DISCARD,
  input wire logic I_SC_UNEXPECTED,
  input wire logic I_SC_OVERRUN,
  input wire logic I_SREQ_DELAYED,
  output logic [31:0] O_CFG_RDATA,
  output logic O_CFG_ACK,
  output logic [7:0] O_IRQ_LINE
);
  logic sel_irq;
  logic sel_cap;
  logic wr_line;
  logic wr_flags;
  logic [7:0] irq_line_ff;
  logic [7:0] nxt_irq_line;
  logic [2:0] clk_code_ff;
  logic [2:0] nxt_clk_code;
  logic clk_legal;
  logic [7:0] pin_byte;
  logic wide_bit;
  logic fast_bit;
  logic [bscr_pkg::BSCR_NUM_FLAGS-1:0] flag_set;
  logic [bscr_pkg::BSCR_NUM_FLAGS-1:0] flag_clr;
  logic [bscr_pkg::BSCR_NUM_FLAGS-1:0] flag_q;
  logic [bscr_pkg::BSCR_NUM_FLAGS-1:0] flag_rd;
  logic [31:0] irq_word;
  logic [31:0] cap_word;

  // dword decode, byte offset low bits ignored
  assign sel_irq = I_CFG_ADDR[7:2] == bscr_pkg::BSCR_OFS_IRQ[7:2];
  assign sel_cap = I_CFG_ADDR[7:2] == bscr_pkg::BSCR_OFS_CAP[7:2];
  assign wr_line = I_CFG_WR & sel_irq & I_CFG_BE[bscr_pkg::BSCR_LANE_LINE];
  assign wr_flags = I_CFG_WR & sel_cap & I_CFG_BE[bscr_pkg::BSCR_LANE_FLAGS];

  assign nxt_irq_line = wr_line ? I_CFG_WDATA[7:0] : irq_line_ff;

  assign clk_legal = (I_SEC_CLK_CODE == bscr_pkg::BSCR_CLK_66) ||
                     (I_SEC_CLK_CODE == bscr_pkg::BSCR_CLK_133);
  assign nxt_clk_code = (I_FWD_MODE && clk_legal) ? I_SEC_CLK_CODE
                                                  : bscr_pkg::BSCR_CLK_CONV;

  // line byte and clock code storage
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      irq_line_ff <= bscr_pkg::BSCR_IRQ_LINE_RST;
      clk_code_ff <= bscr_pkg::BSCR_CLK_RST;
    end else begin
      irq_line_ff <= nxt_irq_line;
      clk_code_ff <= nxt_clk_code;
    end
  end

  assign pin_byte = I_FWD_MODE ? bscr_pkg::BSCR_PIN_FWD : bscr_pkg::BSCR_PIN_REV;
  assign wide_bit = I_FWD_MODE & I_WIDE_BUS_STRAP;
  assign fast_bit = I_FWD_MODE;

  assign flag_set[bscr_pkg::BSCR_FL_DISCARD] = I_SC_DISCARD & I_FWD_MODE;
  assign flag_set[bscr_pkg::BSCR_FL_UNEXP] = I_SC_UNEXPECTED & ~I_FWD_MODE;
  assign flag_set[bscr_pkg::BSCR_FL_OVERRUN] = I_SC_OVERRUN;
  assign flag_set[bscr_pkg::BSCR_FL_DELAYED] = I_SREQ_DELAYED;

  // sticky flags, one per status event
  genvar gi;
  generate
    for (gi = 0; gi < bscr_pkg::BSCR_NUM_FLAGS; gi = gi + 1) begin : g_flag
      assign flag_clr[gi] = wr_flags & I_CFG_WDATA[bscr_pkg::BSCR_FLAG_LSB + gi];
      bscr_sticky_flag u_flag (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_set(flag_set[gi]),
        .i_clr(flag_clr[gi]),
        .o_flag(flag_q[gi])
      );
    end
  endgenerate

  // mode masks on read of the two mode-bound flags
  assign flag_rd = {flag_q[3], flag_q[2],
                    flag_q[1] & ~I_FWD_MODE, flag_q[0] & I_FWD_MODE};

  // read word at the interrupt dword
  assign irq_word = {bscr_pkg::BSCR_MAX_LAT, bscr_pkg::BSCR_MIN_GNT,
                     pin_byte, irq_line_ff};
  // capability dword, reserved top bits zero
  assign cap_word = {7'h00, clk_code_ff, flag_rd, fast_bit, wide_bit,
                     bscr_pkg::BSCR_NEXT_PTR, bscr_pkg::BSCR_CAP_ID};

  // read data and acknowledge
  bscr_cfg_read u_read (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_req(I_CFG_RD | I_CFG_WR),
    .i_rd(I_CFG_RD),
    .i_sel_irq(sel_irq),
    .i_sel_cap(sel_cap),
    .i_irq_word(irq_word),
    .i_cap_word(cap_word),
    .o_rdata(O_CFG_RDATA),
    .o_ack(O_CFG_ACK)
  );

  assign O_IRQ_LINE = irq_line_ff;

  // checks on the register behaviour
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_irq_read;
    I_CFG_RD && !I_CFG_WR && sel_irq ##1 O_CFG_ACK;
  endsequence

  sequence s_cap_read;
    I_CFG_RD && !I_CFG_WR && sel_cap ##1 O_CFG_ACK;
  endsequence

  property p_line_write;
    wr_line |=> O_IRQ_LINE == $past(I_CFG_WDATA[7:0]);
  endproperty
  a_line_write: assert property (p_line_write)
    else $error("line byte did not take written value");

  property p_line_hold;
    !wr_line |=> $stable(O_IRQ_LINE);
  endproperty
  a_line_hold: assert property (p_line_hold)
    else $error("line byte changed without a write");

  property p_pin_byte;
    s_irq_read |-> O_CFG_RDATA[15:8] == ($past(I_FWD_MODE) ? 8'h01 : 8'h00);
  endproperty
  a_pin_byte: assert property (p_pin_byte)
    else $error("pin byte wrong for mode");

  property p_grant_latency;
    s_irq_read |-> O_CFG_RDATA[31:16] == {bscr_pkg::BSCR_MAX_LAT, bscr_pkg::BSCR_MIN_GNT};
  endproperty
  a_grant_latency: assert property (p_grant_latency)
    else $error("grant or latency byte wrong");

  property p_cap_header;
    s_cap_read |-> O_CFG_RDATA[15:0] == 16'h9007;
  endproperty
  a_cap_header: assert property (p_cap_header)
    else $error("capability header wrong");

  property p_wide_bit;
    s_cap_read |-> O_CFG_RDATA[16] == ($past(I_FWD_MODE) && $past(I_WIDE_BUS_STRAP));
  endproperty
  a_wide_bit: assert property (p_wide_bit)
    else $error("wide bus bit wrong");

  property p_fast_bit;
    s_cap_read |-> O_CFG_RDATA[17] == $past(I_FWD_MODE);
  endproperty
  a_fast_bit: assert property (p_fast_bit)
    else $error("fast clock bit wrong");

  property p_discard_set;
    I_SC_DISCARD && I_FWD_MODE |=> flag_q[0];
  endproperty
  a_discard_set: assert property (p_discard_set)
    else $error("discard flag not set");

  property p_discard_rev;
    s_cap_read ##0 !$past(I_FWD_MODE) |-> !O_CFG_RDATA[18];
  endproperty
  a_discard_rev: assert property (p_discard_rev)
    else $error("discard flag visible in reverse mode");

  property p_unexp_set;
    I_SC_UNEXPECTED && !I_FWD_MODE |=> flag_q[1];
  endproperty
  a_unexp_set: assert property (p_unexp_set)
    else $error("unexpected completion flag not set");

  property p_unexp_fwd;
    s_cap_read ##0 $past(I_FWD_MODE) |-> !O_CFG_RDATA[19];
  endproperty
  a_unexp_fwd: assert property (p_unexp_fwd)
    else $error("unexpected flag visible in forward mode");

  property p_overrun_set;
    I_SC_OVERRUN |=> flag_q[2] [*1] ##0 flag_q[2];
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("overrun flag not set");

  property p_delayed_set;
    I_SREQ_DELAYED ##1 I_CFG_RD && !I_CFG_WR && sel_cap |=> O_CFG_RDATA[21];
  endproperty
  a_delayed_set: assert property (p_delayed_set)
    else $error("delayed request flag not read back");

  property p_clk_code;
    s_cap_read |-> O_CFG_RDATA[24:22] <= bscr_pkg::BSCR_CLK_133;
  endproperty
  a_clk_code: assert property (p_clk_code)
    else $error("reserved clock code read back");

  property p_clk_rev;
    !I_FWD_MODE |=> clk_code_ff == bscr_pkg::BSCR_CLK_CONV;
  endproperty
  a_clk_rev: assert property (p_clk_rev)
    else $error("clock code not zero in reverse mode");

  property p_w1c_clear;
    flag_clr[2] && !flag_set[2] |=> !flag_q[2];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear)
    else $error("write one did not clear flag");

  property p_w0_keep;
    wr_flags && !I_CFG_WDATA[21] && flag_q[3] |=> flag_q[3];
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("write zero disturbed flag");

  property p_rsvd_zero;
    s_cap_read |-> O_CFG_RDATA[31:25] == 7'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved status bits not zero");

  property p_discard_ignored;
    I_SC_DISCARD && !I_FWD_MODE && !flag_q[0] |=> !flag_q[0];
  endproperty
  a_discard_ignored: assert property (p_discard_ignored)
    else $error("discard flag set in reverse mode");

  property p_unexp_ignored;
    I_SC_UNEXPECTED && I_FWD_MODE && !flag_q[1] |=> !flag_q[1];
  endproperty
  a_unexp_ignored: assert property (p_unexp_ignored)
    else $error("unexpected flag set in forward mode");

  property p_overrun_hold;
    flag_q[2] && !flag_clr[2] |=> flag_q[2];
  endproperty
  a_overrun_hold: assert property (p_overrun_hold)
    else $error("overrun flag lost without a clear");

  property p_delayed_hold;
    flag_q[3] && !flag_clr[3] |=> flag_q[3];
  endproperty
  a_delayed_hold: assert property (p_delayed_hold)
    else $error("delayed request flag lost without a clear");

  property p_clk_legal;
    I_FWD_MODE && (I_SEC_CLK_CODE == bscr_pkg::BSCR_CLK_66 ||
                   I_SEC_CLK_CODE == bscr_pkg::BSCR_CLK_133)
      |=> clk_code_ff == $past(I_SEC_CLK_CODE);
  endproperty
  a_clk_legal: assert property (p_clk_legal)
    else $error("legal clock code not passed through");

  property p_clk_reserved;
    I_SEC_CLK_CODE > bscr_pkg::BSCR_CLK_133 |=> clk_code_ff == bscr_pkg::BSCR_CLK_CONV;
  endproperty
  a_clk_reserved: assert property (p_clk_reserved)
    else $error("reserved clock code not folded to zero");

  property p_clk_rev_read;
    s_cap_read ##0 !$past(I_FWD_MODE) |-> O_CFG_RDATA[24:22] == bscr_pkg::BSCR_CLK_CONV;
  endproperty
  a_clk_rev_read: assert property (p_clk_rev_read)
    else $error("clock field read nonzero in reverse mode");

  property p_set_wins;
    flag_set[3] && flag_clr[3] |=> flag_q[3];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear won over a same-cycle event");
endmodule : bscr_regs

// ==== bench/tb.sv ====
// self-checking bench for the secondary interrupt and capability slice
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic fwd;
    logic wide;
    logic [2:0] code;
    logic [7:0] addr;
    logic [31:0] exp;
  } bscr_row_s;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic fwd = 1'h1;
  logic wide = 1'h1;
  logic [2:0] code = 3'h0;
  logic [3:0] ev = 4'h0; // discard, unexpected, overrun, delayed
  logic [31:0] rdata;
  logic ack;
  logic [7:0] irq_line;
  int num_errors = 0;
  int check_count = 0;
  bscr_row_s rows [10];

  // device under test
  bscr_regs i_dut (
    .I_MCLK(clk),
    .I_RST(rst),
    .I_CFG_RD(rd),
    .I_CFG_WR(wr),
    .I_CFG_ADDR(addr),
    .I_CFG_BE(be),
    .I_CFG_WDATA(wdata),
    .I_FWD_MODE(fwd),
    .I_WIDE_BUS_STRAP(wide),
    .I_SEC_CLK_CODE(code),
    .I_SC_DISCARD(ev[0]),
    .I_SC_UNEXPECTED(ev[1]),
    .I_SC_OVERRUN(ev[2]),
    .I_SREQ_DELAYED(ev[3]),
    .O_CFG_RDATA(rdata),
    .O_CFG_ACK(ack),
    .O_IRQ_LINE(irq_line)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // drop the request after the taking edge, then wait for ack
  task automatic wait_ack();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    rd = 1'h0;
    wr = 1'h0;
    ev = 4'h0;
    while (ack !== 1'h1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (ack !== 1'h1) begin
      num_errors++;
      $display("CHECK FAILED ack expected 1 seen %b", ack);
      test_done();
    end
    chk("ack latency", 32'h0, 32'(n));
  endtask : wait_ack

  // one config read
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'h1;
    wait_ack();
    chk(name, exp, rdata);
  endtask : cfg_rd

  // one config write, with optional events in the same cycle
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                        input logic [3:0] e);
    @(posedge clk);
    #1;
    addr = a;
    be = b;
    wdata = d;
    ev = e;
    wr = 1'h1;
    wait_ack();
    chk("write rdata", 32'h0, rdata);
  endtask : cfg_wr

  // one-cycle event pulse
  task automatic pulse(input logic [3:0] e);
    @(posedge clk);
    #1;
    ev = e;
    @(posedge clk);
    #1;
    ev = 4'h0;
  endtask : pulse

  // reset held for three cycles with new straps
  task automatic do_reset(input logic f, input logic w, input logic [2:0] c);
    @(posedge clk);
    #1;
    rst = 1'h1;
    fwd = f;
    wide = w;
    code = c;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'h0;
  endtask : do_reset

  // main sequence
  initial begin
    rows = '{
      '{1'h1, 1'h1, 3'h2, 8'h7C, 32'h0000_0100},
      '{1'h1, 1'h1, 3'h2, 8'h80, 32'h0083_9007},
      '{1'h1, 1'h0, 3'h1, 8'h80, 32'h0042_9007},
      '{1'h1, 1'h1, 3'h0, 8'h80, 32'h0003_9007},
      '{1'h1, 1'h1, 3'h3, 8'h80, 32'h0003_9007},
      '{1'h1, 1'h1, 3'h4, 8'h80, 32'h0003_9007},
      '{1'h0, 1'h1, 3'h2, 8'h80, 32'h0000_9007},
      '{1'h0, 1'h1, 3'h2, 8'h7C, 32'h0000_0000},
      '{1'h1, 1'h1, 3'h2, 8'h84, 32'h0000_0000},
      '{1'h1, 1'h1, 3'h2, 8'h83, 32'h0083_9007}
    };
    for (int i = 0; i < 10; i++) begin
      do_reset(rows[i].fwd, rows[i].wide, rows[i].code);
      cfg_rd(rows[i].addr, rows[i].exp, "table read");
    end
    do_reset(1'h1, 1'h1, 3'h0);
    chk("irq line reset", 32'h0, {24'h0, irq_line});
    cfg_wr(8'h7C, 4'h1, 32'hFFFF_FFA5, 4'h0);
    chk("irq line", 32'hA5, {24'h0, irq_line});
    cfg_wr(8'h7C, 4'hE, 32'h0000_005A, 4'h0);
    cfg_rd(8'h7C, 32'h0000_01A5, "line lane off");
    cfg_wr(8'h7C, 4'hF, 32'h1234_56C3, 4'h0);
    cfg_rd(8'h7C, 32'h0000_01C3, "ro bytes");
    pulse(4'hF);
    cfg_rd(8'h80, 32'h0037_9007, "fwd flags");
    cfg_wr(8'h80, 4'hB, 32'hFFFF_FFFF, 4'h0);
    cfg_rd(8'h80, 32'h0037_9007, "flags lane off");
    cfg_wr(8'h80, 4'h4, 32'h0010_0000, 4'h0);
    cfg_rd(8'h80, 32'h0027_9007, "clear one");
    cfg_wr(8'h80, 4'h4, 32'h0000_0000, 4'h0);
    cfg_rd(8'h80, 32'h0027_9007, "write zero");
    cfg_wr(8'h80, 4'hF, 32'hFFFF_FFFF, 4'h0);
    cfg_rd(8'h80, 32'h0003_9007, "clear all");
    // event directly followed by a read
    @(posedge clk);
    #1;
    ev = 4'h8;
    cfg_rd(8'h80, 32'h0023_9007, "event then read");
    cfg_wr(8'h80, 4'h4, 32'hFFFF_FFFF, 4'h8);
    cfg_rd(8'h80, 32'h0023_9007, "set wins");
    do_reset(1'h0, 1'h1, 3'h2);
    pulse(4'hF);
    cfg_rd(8'h80, 32'h0038_9007, "rev flags");
    cfg_wr(8'h80, 4'h4, 32'h0008_0000, 4'h0);
    cfg_rd(8'h80, 32'h0030_9007, "rev clear");
    // flags cleared by the next reset
    do_reset(1'h1, 1'h1, 3'h2);
    cfg_rd(8'h80, 32'h0083_9007, "flags reset");
    test_done();
  end
endmodule : tb
